/* rtl/adc_ctrl_pkg.sv */
// Package for the converter/comparator control block.
// Assumes one 125 MHz clock; a machine cycle is a divided enable pulse.
package adc_ctrl_pkg;
  // ------------------------------------------------------------
  // Register map (word index, byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE = 4'h0;      // converter_mode_reg
  localparam logic [3:0] ADDR_IRQ2 = 4'h1;      // second_irq_control_reg
  localparam logic [3:0] ADDR_CMD = 4'h2;       // instruction strobes
  localparam logic [3:0] ADDR_RESULT = 4'h3;    // result / reference
  localparam logic [3:0] ADDR_STATUS = 4'h4;    // sticky events
  localparam logic [3:0] ADDR_MASK = 4'h5;      // event mask
  localparam logic [3:0] ADDR_ACC = 4'h6;       // accumulator
  localparam logic [3:0] ADDR_PINSEL = 4'h7;    // analog pin claim
  localparam logic [3:0] ADDR_PORT = 4'h8;      // port output latches / pins
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MODE_CMP_BIT = 3;      // 1 = comparator mode
  localparam int IRQ2_ADC_EN_BIT = 2;   // converter interrupt enable
  localparam int CMD_START_BIT = 0;     // begin_conversion_instr
  localparam int CMD_SKIPCLR_BIT = 1;   // skip_clear_done_instr
  localparam int CMD_MOVELO_BIT = 2;    // move_result_low_instr
  localparam int ST_DONE_BIT = 0;
  localparam int ST_RESTART_BIT = 1;
  localparam int ST_SKIP_BIT = 2;       // a skip-clear found flag set
  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] IRQ2_RESET = 4'h0;
  localparam logic [7:0] PINSEL_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam int RES_W = 10;
  localparam int CLK_MHZ = 125;
  localparam int MACH_NS = 1000;                        // machine cycle, ns
  localparam int MACH_DIV = (MACH_NS * CLK_MHZ) / 1000; // clocks per machine cycle
  localparam int CMP_MC = 8;                            // comparison length
  localparam int SAR_MC_PER_BIT = 1;
  localparam logic [1:0] SETTLE_CLKS = 2'h2;            // synchroniser stages before a decision
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAR = 3'b010,
    ST_CMP = 3'b100
  } conv_state_e;
endpackage

/* rtl/adc_ctrl_if.sv */
// Interface between control logic and the analog front end model.
// Assumes one clock domain; the control side owns sample requests.
`timescale 1ns/1ps
interface adc_ctrl_if;
  logic [2:0] chan;
  logic [9:0] dac_code;
  logic cmp_hi;
  modport ctrl (output chan, output dac_code, input cmp_hi);
  modport front (input chan, input dac_code, output cmp_hi);
endinterface

/* rtl/machine_tick.sv */
// Machine-cycle enable divider.
// Assumes a free running clk; emits one-cycle pulses.
`timescale 1ns/1ps
module machine_tick
  import adc_ctrl_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, low
  output logic tick // one pulse per machine cycle
);
  logic [7:0] cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == 8'(MACH_DIV - 1)) begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // machine_tick

/* rtl/adc_comparator_control.sv */
// Converter / comparator control: SAR sequencing, comparator timing,
// done flag, interrupt, pin claim and low-result transfer.
// Assumes an analog front end giving a synchronous-ish compare bit.
//
// Contract
// R1 - Restart during conversion discards and begins again
// R2 - Software keeps mode bit during activity
// R3 - Software clears interrupt enable before leaving comparator
// R4 - Mode change may set done flag
// R5 - Software skip-clears flag after mode write
// R6 - Comparator input above reference keeps flag clear
// R7 - Clear flag after comparison raises no interrupt
// R8 - Comparison finishes eight machine cycles after start
// R9 - Software polls flag after comparison time
// R10 - Analog-selected pins leave general-purpose port duty
// R11 - Low transfer: result bits to acc 3:2
// R12 - Ten-bit SAR result; flag set at last
// R13 - Comparator reference from result; flag means below
`timescale 1ns/1ps
module adc_comparator_control
  import adc_ctrl_pkg::*;
(
  input wire logic clk, // 125 MHz system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [3:0] addr, // register index
  input wire logic [31:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd_en
  output logic irq, // level interrupt
  output logic [2:0] analog_chan, // selected analog input
  output logic [9:0] dac_code, // SAR trial or comparator reference
  input wire logic cmp_hi, // analog input above dac level (async)
  input wire logic [7:0] port_pin_in, // shared_port_b/c pin levels
  output logic [7:0] port_out, // shared port output levels
  output logic [7:0] port_oe // shared port output enables
);
  // ------------------------------------------------------------
  // Machine-cycle enable and front end link
  // ------------------------------------------------------------
  logic mtick;
  machine_tick u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .tick(mtick)
  );
  adc_ctrl_if fe ();
  assign analog_chan = fe.chan;
  assign dac_code = fe.dac_code;
  assign fe.cmp_hi = cmp_hi;

  // Compare bit and pin levels come from outside the clock domain
  logic cmp_s1, cmp_s2;
  logic [7:0] pin_s1, pin_s2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
    end else begin
      cmp_s1 <= fe.cmp_hi;
      cmp_s2 <= cmp_s1;
      pin_s1 <= port_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  logic [3:0] converter_mode_reg;
  logic [3:0] second_irq_control_reg;
  logic [7:0] pin_sel;
  logic [7:0] port_latch;
  logic [3:0] acc;
  logic [RES_W-1:0] result;
  logic [2:0] status;
  logic [2:0] mask;
  logic wr_mode, wr_cmd, wr_result;
  logic wr_irq2, wr_pinsel, wr_port, wr_mask, wr_acc, wr_status;
  logic start_instr, skipclr_instr, movelo_instr;

  // One strobe-and-index match, shared by every register write decode
  function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] idx);
    return strobe && a == idx;
  endfunction

  assign wr_mode = hit(wr_en, addr, ADDR_MODE);
  assign wr_cmd = hit(wr_en, addr, ADDR_CMD);
  assign wr_result = hit(wr_en, addr, ADDR_RESULT);
  assign wr_irq2 = hit(wr_en, addr, ADDR_IRQ2);
  assign wr_pinsel = hit(wr_en, addr, ADDR_PINSEL);
  assign wr_port = hit(wr_en, addr, ADDR_PORT);
  assign wr_mask = hit(wr_en, addr, ADDR_MASK);
  assign wr_acc = hit(wr_en, addr, ADDR_ACC);
  assign wr_status = hit(wr_en, addr, ADDR_STATUS);
  assign start_instr = wr_cmd && wdata[CMD_START_BIT];
  assign skipclr_instr = wr_cmd && wdata[CMD_SKIPCLR_BIT];
  assign movelo_instr = wr_cmd && wdata[CMD_MOVELO_BIT];

  // One process per register keeps each reset value beside its write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      converter_mode_reg <= wdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_irq_control_reg <= IRQ2_RESET;
    end else if (wr_irq2) begin
      second_irq_control_reg <= wdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sel <= PINSEL_RESET;
    end else if (wr_pinsel) begin
      pin_sel <= wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_latch <= 8'h00;
    end else if (wr_port) begin
      port_latch <= wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask <= MASK_RESET;
    end else if (wr_mask) begin
      mask <= wdata[2:0];
    end
  end

  // Low-result transfer writes the accumulator as well as plain writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= 4'h0;
    end else if (movelo_instr) begin
      acc <= {result[1:0], 2'b00}; // [R11]
    end else if (wr_acc) begin
      acc <= wdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // Conversion / comparison sequencer
  // ------------------------------------------------------------
  conv_state_e state;
  logic [3:0] bit_idx;
  logic [3:0] mc_cnt;
  logic cmp_mode;
  logic mode_prev;
  logic seq_done, cmp_below, mode_to_conv;

  assign cmp_mode = converter_mode_reg[MODE_CMP_BIT];
  assign mode_to_conv = mode_prev && !cmp_mode;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_prev <= 1'b0;
    end else begin
      mode_prev <= cmp_mode;
    end
  end

  // ------------------------------------------------------------
  // Decision settle guard
  // ------------------------------------------------------------
  // The compare bit lags the trial level by the two synchroniser
  // stages, so a tick that lands right after a start is skipped;
  // the cost is at most one extra machine cycle per run.
  logic [1:0] settle;
  logic step;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle <= 2'h0;
    end else if (start_instr) begin
      settle <= SETTLE_CLKS;
    end else if (settle != 2'h0) begin
      settle <= settle - 2'h1;
    end
  end

  assign step = mtick && settle == 2'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      bit_idx <= 4'h0;
      mc_cnt <= 4'h0;
    end else if (start_instr) begin
      // Any run in progress is dropped and a fresh one begins
      state <= cmp_mode ? ST_CMP : ST_SAR; // [R1]
      bit_idx <= 4'(RES_W - 1);
      mc_cnt <= 4'h0;
    end else if (step) begin
      unique case (state)
        ST_IDLE: ;
        ST_SAR: begin
          if (bit_idx == 4'h0) begin
            state <= ST_IDLE;
          end else begin
            bit_idx <= bit_idx - 4'h1;
          end
        end
        ST_CMP: begin
          if (mc_cnt == 4'(CMP_MC - 1)) begin
            state <= ST_IDLE; // [R8]
          end else begin
            mc_cnt <= mc_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  assign seq_done = step && !start_instr &&
    ((state == ST_SAR && bit_idx == 4'h0) ||
     (state == ST_CMP && mc_cnt == 4'(CMP_MC - 1)));
  // Comparator reports below only when input is not above reference
  assign cmp_below = !cmp_s2; // [R13]

  // Result register: SAR bits, or reference written by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= '0;
    end else if (start_instr && !cmp_mode) begin
      result <= '0;
    end else if (wr_result) begin
      result <= wdata[RES_W-1:0]; // [R13]
    end else if (step && !start_instr && state == ST_SAR) begin
      // Input above the trial level keeps the bit under test
      result[bit_idx] <= cmp_s2; // [R12]
    end
  end

  // Lowest claimed pin feeds the converter; with none claimed, input 0
  always_comb begin
    fe.chan = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pin_sel[i]) begin
        fe.chan = 3'(i);
      end
    end
  end

  // SAR trial level: decided bits plus the bit under test
  always_comb begin
    fe.dac_code = result;
    if (state == ST_SAR) begin
      fe.dac_code = result | (10'h001 << bit_idx); // [R12]
    end
  end

  // ------------------------------------------------------------
  // Completion flag and sticky events
  // ------------------------------------------------------------
  logic conversion_done_flag;
  logic done_set;
  // Mode change back to conversion may glitch the flag high, as the
  // real converter does; software is expected to skip-clear it.
  assign done_set = (seq_done && (state == ST_SAR || cmp_below)) // [R6] [R12]
    || mode_to_conv; // [R4]

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conversion_done_flag <= 1'b0;
    end else if (done_set) begin
      conversion_done_flag <= 1'b1; // set wins over clear
    end else if (skipclr_instr || start_instr) begin
      conversion_done_flag <= 1'b0;
    end
  end

  logic [2:0] ev;
  assign ev[ST_DONE_BIT] = done_set && second_irq_control_reg[IRQ2_ADC_EN_BIT]; // [R7]
  assign ev[ST_RESTART_BIT] = start_instr && state != ST_IDLE; // [R1]
  assign ev[ST_SKIP_BIT] = skipclr_instr && conversion_done_flag;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // A same-cycle event beats the software clear of its bit
        if (ev[i]) begin
          status[i] <= 1'b1;
        end else if (wr_status && wdata[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  // Level output: high until software clears or masks every event
  assign irq = |(status & mask);

  // ------------------------------------------------------------
  // Shared port pins
  // ------------------------------------------------------------
  // Claimed pins stop driving and read back as zero
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign port_oe[g] = !pin_sel[g] && !port_latch[g]; // [R10]
      assign port_out[g] = 1'b0;
    end
  endgenerate

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr)
        ADDR_MODE: rdata <= {28'h0, converter_mode_reg};
        ADDR_IRQ2: rdata <= {28'h0, second_irq_control_reg};
        ADDR_CMD: rdata <= {29'h0, state != ST_IDLE, conversion_done_flag, 1'b0};
        ADDR_RESULT: rdata <= {22'h0, result};
        ADDR_STATUS: rdata <= {29'h0, status};
        ADDR_MASK: rdata <= {29'h0, mask};
        ADDR_ACC: rdata <= {28'h0, acc};
        ADDR_PINSEL: rdata <= {24'h0, pin_sel};
        ADDR_PORT: rdata <= {24'h0, pin_s2 & ~pin_sel}; // [R10]
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      // Idle cycles read zero so a stale word never looks like data
      rdata <= 32'h0000_0000;
    end
  end
endmodule // adc_comparator_control

/* testbench/analog_source.sv */
// Behavioural analog source feeding the converter compare input.
// Assumes the level table is in half steps: code L sits at 2L+1.
`timescale 1ns/1ps
module analog_source (
  input wire logic [2:0] analog_chan, // selected input
  input wire logic [9:0] dac_code, // trial or reference level
  input wire logic [7:0][10:0] lvl, // per-input level, half steps
  output logic cmp_hi // input above dac level
);
  // Half-step levels keep the compare from ever landing on a tie
  assign cmp_hi = lvl[analog_chan] > {dac_code, 1'b0};
endmodule // analog_source

/* testbench/adc_ctrl_monitor.sv */
// Port-level checker for the converter/comparator control block.
// Assumes software never writes the mode bit mid-operation.
`timescale 1ns/1ps
module adc_ctrl_monitor
  import adc_ctrl_pkg::*;
(
  input wire logic clk, // clock
  input wire logic arst_n, // async reset, low
  input wire logic [3:0] addr, // register index
  input wire logic [31:0] wdata, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic irq, // interrupt
  input wire logic [9:0] dac_code, // dac level
  input wire logic [7:0] port_oe // port enables
);
  // Tick phase is unknown, so busy windows carry one machine cycle of slack
  localparam int CONV_LO = 1120;
  localparam int CONV_HI = 1255;
  localparam int CMP_LO = 870;
  localparam int CMP_HI = 1005;
  logic mode_m;
  logic cmp_run;
  logic [2:0] mask_m;
  logic [7:0] pinsel_m;
  logic [15:0] cnt;
  logic wr_cmd;
  logic go;
  assign wr_cmd = wr_en && addr == ADDR_CMD;
  assign go = wr_cmd && wdata[CMD_START_BIT];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_m <= 1'b0;
      cmp_run <= 1'b0;
      mask_m <= MASK_RESET;
      pinsel_m <= PINSEL_RESET;
      cnt <= 16'hFFFF;
    end else begin
      if (wr_en && addr == ADDR_MODE) mode_m <= wdata[MODE_CMP_BIT];
      if (wr_en && addr == ADDR_MASK) mask_m <= wdata[2:0];
      if (wr_en && addr == ADDR_PINSEL) pinsel_m <= wdata[7:0];
      if (go) begin
        cnt <= 16'h0000;
        cmp_run <= mode_m;
      end else if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd_cmd; rd_en && addr == ADDR_CMD; endsequence
  sequence s_move; wr_cmd && wdata[CMD_MOVELO_BIT]; endsequence
  property p_rd_idle; !rd_en |=> rdata == 32'h0; endproperty
  property p_start_dac; go && !mode_m |=> dac_code == 10'h200; endproperty
  property p_cmp_hold; go && mode_m |=> $stable(dac_code) [*8]; endproperty
  property p_busy_hi;
    s_rd_cmd |=> !rdata[2] || cnt <= (cmp_run ? CMP_HI : CONV_HI);
  endproperty
  property p_busy_lo;
    s_rd_cmd |=> rdata[2] || cnt >= (cmp_run ? CMP_LO : CONV_LO);
  endproperty
  property p_move_lo;
    s_move ##[1:2] (rd_en && addr == ADDR_ACC) |=> rdata[1:0] == 2'b00;
  endproperty
  property p_port_claim;
    rd_en && addr == ADDR_PORT |=> (rdata[7:0] & pinsel_m) == 8'h00;
  endproperty
  property p_oe_claim; (port_oe & pinsel_m) == 8'h00; endproperty
  property p_irq_mask; mask_m == 3'h0 |-> !irq; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
  a_start_dac: assert property (p_start_dac) else $error("bad first trial");
  a_cmp_hold: assert property (p_cmp_hold) else $error("reference moved");
  a_busy_hi: assert property (p_busy_hi) else $error("busy too long");
  a_busy_lo: assert property (p_busy_lo) else $error("busy too short");
  a_move_lo: assert property (p_move_lo) else $error("acc low not zero");
  a_port_claim: assert property (p_port_claim) else $error("claimed pin read");
  a_oe_claim: assert property (p_oe_claim) else $error("claimed pin driven");
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
endmodule // adc_ctrl_monitor
bind adc_comparator_control adc_ctrl_monitor u_mon (.clk(clk), .arst_n(arst_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
  .dac_code(dac_code), .port_oe(port_oe));

/* testbench/testbench.sv */
// Self-checking bench for the converter/comparator control block.
// Assumes the register map of adc_ctrl_pkg and a 125 MHz clock.
`timescale 1ns/1ps
module testbench;
  import adc_ctrl_pkg::*;
  logic clk, arst_n, wr_en, rd_en, irq, cmp_hi;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [2:0] analog_chan;
  logic [9:0] dac_code;
  logic [7:0] port_pin_in, port_out, port_oe;
  logic [7:0][10:0] lvl;
  logic [3:0] ra [4] = '{ADDR_MODE, ADDR_IRQ2, ADDR_MASK, ADDR_PINSEL};
  int err_count, n_tests, t;
  adc_comparator_control uut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .analog_chan(analog_chan),
    .dac_code(dac_code), .cmp_hi(cmp_hi), .port_pin_in(port_pin_in),
    .port_out(port_out), .port_oe(port_oe));
  analog_source src (.analog_chan(analog_chan), .dac_code(dac_code), .lvl(lvl),
    .cmp_hi(cmp_hi));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // --------------------------------------------------
  // Bus tasks; each access leaves an idle edge behind
  // --------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 q = rdata;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  // Bounded poll on busy; t counts clocks since the start write returned
  task automatic wait_idle();
    t = 2;
    rd(ADDR_CMD);
    while (q[2] !== 1'b0 && t < 3000) begin
      rd(ADDR_CMD);
      t = t + 2;
    end
    if (q[2] !== 1'b0) begin
      err_count++;
      $display("FAIL %0t busy never dropped", $time);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    wrap_up();
  end
  initial begin
    arst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    port_pin_in = 8'hFF;
    lvl = '0;
    lvl[0] = {10'h2A5, 1'b1};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk(port_oe, 32'hFF);
    chk(port_out, 32'h0);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(q, 32'h0);
    end
    wr(ADDR_IRQ2, 32'h4);
    wr(ADDR_CMD, 32'h1);
    repeat (300) @(posedge clk);
    wr(ADDR_CMD, 32'h1);
    wait_idle();
    chk(t >= 1120 && t <= 1256, 1);
    chk(q[1], 1);
    rd(ADDR_RESULT);
    chk(q, 32'h2A5);
    rd(ADDR_STATUS);
    chk(q, 32'h3);
    chk(irq, 0);
    wr(ADDR_MASK, 32'h1);
    chk(irq, 1);
    wr(ADDR_STATUS, 32'h3);
    chk(irq, 0);
    wr(ADDR_ACC, 32'hF);
    wr(ADDR_CMD, 32'h4);
    rd(ADDR_ACC);
    chk(q, 32'h4);
    // Comparator: below, then above the reference
    wr(ADDR_MODE, 32'h8);
    wr(ADDR_RESULT, 32'h100);
    lvl[0] <= {10'h080, 1'b1};
    wr(ADDR_CMD, 32'h1);
    chk(dac_code, 32'h100);
    wait_idle();
    chk(t >= 860 && t <= 1010, 1);
    chk(q[1], 1);
    chk(irq, 1);
    wr(ADDR_STATUS, 32'h7);
    lvl[0] <= {10'h180, 1'b1};
    wr(ADDR_CMD, 32'h1);
    wait_idle();
    chk(q[1], 0);
    chk(irq, 0);
    wr(ADDR_IRQ2, 32'h0);
    wr(ADDR_MODE, 32'h0);
    rd(ADDR_CMD);
    chk(q[1], 1);
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_CMD);
    chk(q[1], 0);
    rd(ADDR_STATUS);
    chk(q, 32'h4);
    wr(ADDR_PINSEL, 32'h0C);
    chk(analog_chan, 32'h2);
    wr(ADDR_PORT, 32'hFF);
    chk(port_oe, 32'h0);
    rd(ADDR_PORT);
    chk(q, 32'hF3);
    wr(ADDR_PORT, 32'h0);
    chk(port_oe, 32'hF3);
    rd(4'hF);
    chk(q, 32'h0);
    wrap_up();
  end
endmodule // testbench
